// ==== sim/ppm_csr_monitor.sv ====
`default_nettype none

// ----------------------------------------------------------------------
// Port checker for the power state register block
// ----------------------------------------------------------------------
module ppm_csr_monitor
    import ppm_pkg::*;
(
    input  wire logic          i_clock,
    input  wire logic          i_rst_b,
    input  wire logic          i_bus_reset_input_b,
    input  wire ppm_cfg_req_s  i_cfg_req,
    input  wire logic          i_wake_event,
    input  wire ppm_cfg_rsp_s  o_cfg_rsp,
    input  wire logic          o_wake_pin_out,
    input  wire logic          o_wake_pin_oe_b,
    input  wire logic          o_d3_exit_reset,
    input  wire ppm_sec_bus_s  o_sec_bus,
    input  wire ppm_level_t    o_power_level
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    logic        hit;
    logic [1:0]  lvl_w_r;
    logic [1:0]  rel_r;

    // A hit covers the whole dword that starts at the control register.
    assign hit = (i_cfg_req.addr[7:2] == 6'h29);

    // Last level written; the bus reset synchroniser needs two edges to clear.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lvl_w_r <= 2'h0;
            rel_r   <= 2'h0;
        end else begin
            if (i_cfg_req.wr && hit && i_cfg_req.be[0]) begin
                lvl_w_r <= i_cfg_req.wdata[1:0];
            end
            if (rel_r != 2'h3) begin
                rel_r <= rel_r + 2'h1;
            end
        end
    end

    a_mult_zero: assert property (o_cfg_rsp.ack |-> o_cfg_rsp.rdata[14:13] == 2'h0)
        else $error("multiplier field not zero");
    a_sel_zero: assert property (o_cfg_rsp.ack |-> o_cfg_rsp.rdata[12:9] == 4'h0)
        else $error("selector field not zero");
    a_rsvd_zero: assert property (o_cfg_rsp.ack |-> o_cfg_rsp.rdata[7:2] == 6'h00)
        else $error("reserved bits not zero");
    a_ext_fixed: assert property ((i_cfg_req.rd && hit) |=> o_cfg_rsp.rdata[31:16] == 16'h00c0)
        else $error("upper bytes not fixed");
    a_level_write: assert property ((i_cfg_req.wr && hit && i_cfg_req.be[0] && rel_r == 2'h3
        && i_bus_reset_input_b && $past(i_bus_reset_input_b) && $past(i_bus_reset_input_b, 2))
        |-> ##[1:2] (o_power_level == lvl_w_r))
        else $error("power level did not follow write");
    a_d3_exit: assert property (o_d3_exit_reset |-> $past(i_cfg_req.wr && hit
        && i_cfg_req.be[0] && i_cfg_req.wdata[1:0] == 2'h0))
        else $error("exit pulse without a write to D0");
    a_pin_cause: assert property ($fell(o_wake_pin_oe_b) |-> $past(i_wake_event
        || (i_cfg_req.wr && hit && i_cfg_req.be[1])))
        else $error("wake pin driven without cause");
    a_clear_rel: assert property ((i_cfg_req.wr && hit && i_cfg_req.be[1]
        && i_cfg_req.wdata[15] && !i_wake_event) |=> o_wake_pin_oe_b)
        else $error("wake pin held after clear");
    a_b2_stop: assert property ((o_power_level == 2'h3) [*3]
        |-> (o_sec_bus.clk_stop && !o_sec_bus.power_off))
        else $error("secondary clock not stopped in D3hot");
    a_bus_run: assert property ((o_power_level != 2'h3) [*3]
        |-> (!o_sec_bus.clk_stop && !o_sec_bus.power_off))
        else $error("secondary bus stopped outside D3hot");
endmodule

`default_nettype wire

// ==== sim/ppm_csr_tb_top.sv ====
`default_nettype none

// ----------------------------------------------------------------------
// Self checking bench for the power state register block
// ----------------------------------------------------------------------
module ppm_csr_tb_top
    import ppm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic          i_clock = 1'b0;
    logic          i_rst_b = 1'b0;
    logic          bus_rst_b = 1'b1;
    ppm_cfg_req_s  req = '0;
    logic          wake_ev = 1'b0;
    ppm_cfg_rsp_s  rsp;
    logic          pin_out;
    logic          pin_oe_b;
    logic          d3_exit;
    ppm_sec_bus_s  sec;
    ppm_level_t    level;
    logic          d3_seen;
    logic [31:0]   r;
    logic [31:0]   seed = 32'hc990;
    int            error_cnt = 0;
    int            check_count = 0;
    int            cyc = 0;
    int            lvl = 0;
    int            en = 0;
    int            flag = 0;
    int            old;

    // Free running clock at 25 MHz.
    always #20 i_clock = ~i_clock;

    ppm_csr dut (
        .i_clock             (i_clock),
        .i_rst_b             (i_rst_b),
        .i_bus_reset_input_b (bus_rst_b),
        .i_cfg_req           (req),
        .i_wake_event        (wake_ev),
        .o_cfg_rsp           (rsp),
        .o_wake_pin_out      (pin_out),
        .o_wake_pin_oe_b     (pin_oe_b),
        .o_d3_exit_reset     (d3_exit),
        .o_sec_bus           (sec),
        .o_power_level       (level)
    );

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // A hang is cut short well above the some 165 cycles the run needs.
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            results();
        end
    end

    function automatic logic [31:0] nxt_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected dword at the control register from the bench model.
    function automatic logic [31:0] exp_dw();
        return {16'h00c0, flag[0], 6'h00, en[0], 6'h00, lvl[1:0]};
    endfunction

    // ------------------------------------------------------------------
    // Stimulus tasks, all driven at the falling edge
    // ------------------------------------------------------------------
    task automatic cfg(input logic w, input logic rd, input logic [7:0] a,
                       input logic [3:0] be, input logic [31:0] wd);
        @(negedge i_clock);
        req = '{wr: w, rd: rd, addr: a, be: be, wdata: wd};
        @(negedge i_clock);
        // The answer and the exit pulse stand for one cycle only, so they are
        // taken here, half a cycle after the edge that launched them.
        chk("ack", {31'h0, rsp.ack}, 32'h1);
        r = rsp.rdata;
        d3_seen = d3_exit;
        req = '0;
    endtask

    // Write the control register and update the model the same way.
    task automatic wrm(input logic [3:0] be, input logic [31:0] wd);
        cfg(1'b1, 1'b0, 8'ha4, be, wd);
        chk("write rdata", r, 32'h0);
        if (be[0]) lvl = wd[1:0];
        if (be[1]) en = wd[8];
        if (be[1] && wd[15]) flag = 0;
    endtask

    task automatic rdc();
        cfg(1'b0, 1'b1, 8'ha4, 4'hf, 32'h0);
        chk("csr", r, exp_dw());
        chk("pin_oe_b", {31'h0, pin_oe_b}, {31'h0, !(en && flag)});
        chk("pin_out", {31'h0, pin_out}, 32'h0);
    endtask

    task automatic wake();
        @(negedge i_clock);
        wake_ev = 1'b1;
        @(negedge i_clock);
        wake_ev = 1'b0;
        flag = 1;
        chk("wake pin", {31'h0, pin_oe_b}, {31'h0, !en});
    endtask

    // Bus reset spares the enable, and the flag while waking is enabled.
    task automatic brst();
        @(negedge i_clock);
        bus_rst_b = 1'b0;
        repeat (4) @(negedge i_clock);
        bus_rst_b = 1'b1;
        repeat (4) @(negedge i_clock);
        lvl = 0;
        if (!en) flag = 0;
    endtask

    task automatic global_reset_input();
        @(negedge i_clock);
        i_rst_b = 1'b0;
        repeat (10) @(negedge i_clock);
        i_rst_b = 1'b1;
        repeat (5) @(negedge i_clock);
        lvl = 0;
        en = 0;
        flag = 0;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        global_reset_input();
        rdc();
        cfg(1'b0, 1'b1, 8'ha7, 4'hf, 32'h0);
        chk("upper", {16'h0, r[31:16]}, 32'h0000_00c0);
        cfg(1'b0, 1'b1, 8'ha0, 4'hf, 32'h0);
        chk("miss", r, 32'h0);
        wrm(4'hf, 32'hffff_ffff);
        rdc();
        repeat (3) @(negedge i_clock);
        chk("sec_bus", {30'h0, sec}, 32'h2);
        wrm(4'h1, 32'h0);
        chk("d3_exit", {31'h0, d3_seen}, 32'h1);
        rdc();
        chk("sec_bus", {30'h0, sec}, 32'h0);
        // Random levels; the exit pulse must appear only on D3hot to D0.
        for (int i = 0; i < 16; i++) begin
            seed = nxt_rand(seed);
            old = lvl;
            wrm(4'h1, seed);
            chk("d3_exit", {31'h0, d3_seen}, {31'h0, old == 3 && seed[1:0] == 2'h0});
            rdc();
            chk("level", {30'h0, level}, lvl);
        end
        wake();
        rdc();
        wrm(4'h2, 32'h0000_0100);
        rdc();
        wrm(4'h2, 32'h0000_8100);
        rdc();
        wake();
        brst();
        rdc();
        wrm(4'h2, 32'h0000_0000);
        rdc();
        wake();
        rdc();
        brst();
        rdc();
        wrm(4'hc, 32'hffff_ffff);
        rdc();
        wrm(4'h2, 32'h0000_0100);
        global_reset_input();
        rdc();
        results();
    end
endmodule

bind ppm_csr ppm_csr_monitor u_mon (
    .i_clock             (i_clock),
    .i_rst_b             (i_rst_b),
    .i_bus_reset_input_b (i_bus_reset_input_b),
    .i_cfg_req           (i_cfg_req),
    .i_wake_event        (i_wake_event),
    .o_cfg_rsp           (o_cfg_rsp),
    .o_wake_pin_out      (o_wake_pin_out),
    .o_wake_pin_oe_b     (o_wake_pin_oe_b),
    .o_d3_exit_reset     (o_d3_exit_reset),
    .o_sec_bus           (o_sec_bus),
    .o_power_level       (o_power_level)
);

`default_nettype wire

// ==== verilog/ppm_consts.svh ====
`ifndef PPM_CONSTS_SVH
`define PPM_CONSTS_SVH

// ----------------------------------------------------------------------
// Configuration space placement
// ----------------------------------------------------------------------
`define PPM_CSR_OFFSET      8'ha4
`define PPM_BSE_OFFSET      8'ha6
`define PPM_DATA_OFFSET     8'ha7
`define PPM_ADDR_W          8
`define PPM_DATA_W          32
`define PPM_BE_W            4

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PPM_FLAG_BIT        15
`define PPM_EN_BIT          8
`define PPM_LEVEL_MSB       1
`define PPM_LEVEL_LSB       0
`define PPM_LANE_LEVEL      0
`define PPM_LANE_CTRL       1
`define PPM_LANE_FLAG_BIT   7
`define PPM_LANE_EN_BIT     0

// ----------------------------------------------------------------------
// Reset and fixed values
// ----------------------------------------------------------------------
`define PPM_CSR_RESET       16'h0000
`define PPM_BSE_RESET       8'hc0
`define PPM_DATA_RESET      8'h00
`define PPM_LEVEL_D0        2'h0
`define PPM_LEVEL_D3HOT     2'h3
`define PPM_BPCC_BIT        7
`define PPM_B2B3_BIT        6

`endif

// ==== verilog/ppm_csr.sv ====
`default_nettype none
`include "ppm_consts.svh"

// Notes on behaviour
// - Internal D3hot exit reset spares this register.
// - D3hot to D0 resets rest of function.
// - Wake flag sets on event, enable ignored.
// - Writing one clears flag, releases wake pin.
// - Data multiplier field reads zero.
// - Data selector field reads zero.
// - Wake pin driven only when enabled.
// - Wake enable cleared only by global reset.
// - Bus reset clears flag only when disabled.
// - Reserved bits of both registers read zero.
// - Power level reports and sets state.
// - Bus power clock control reads one.
// - Without bus control, level leaves bus alone.
// - Hot state action bit picks B2 or B3.
// - Power data register reads zero.

module ppm_csr
    import ppm_pkg::*;
(
    input  wire logic           i_clock,
    input  wire logic           i_rst_b,
    input  wire logic           i_bus_reset_input_b,
    input  wire ppm_cfg_req_s   i_cfg_req,
    input  wire logic           i_wake_event,
    output ppm_cfg_rsp_s        o_cfg_rsp,
    output logic                o_wake_pin_out,
    output logic                o_wake_pin_oe_b,
    output logic                o_d3_exit_reset,
    output ppm_sec_bus_s        o_sec_bus,
    output ppm_level_t          o_power_level
);

    // ------------------------------------------------------------------
    // Fixed register contents
    // ------------------------------------------------------------------

    // These values are constants, so no write path can reach them.
    localparam logic [7:0] BSE_VALUE  = `PPM_BSE_RESET;
    localparam logic [7:0] DATA_VALUE = `PPM_DATA_RESET;
    localparam logic       SECONDARY_BUS_POWER_CLOCK_CTL    = BSE_VALUE[`PPM_BPCC_BIT];
    localparam logic       B2B3_SEL   = BSE_VALUE[`PPM_B2B3_BIT];

    // Dword index of the power management group.
    localparam logic [5:0] CSR_DWORD  = 6'(`PPM_CSR_OFFSET >> 2);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------

    ppm_level_t         level_r;
    logic               wake_en_r;
    logic               wake_flag_r;
    logic               bus_rst_b_s;
    logic               bus_rst;

    // ------------------------------------------------------------------
    // Bus reset synchroniser
    // ------------------------------------------------------------------

    // The bus reset pin is not on this clock, so it is synchronised
    // before any register looks at it; it then acts as a clocked clear.
    ppm_sync2 u_bus_rst_sync (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_async (i_bus_reset_input_b),
        .o_sync  (bus_rst_b_s)
    );

    assign bus_rst = ~bus_rst_b_s;

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------

    // True when a write hits the power management dword on one lane.
    function automatic logic lane_write(
        input ppm_cfg_req_s req,
        input int unsigned  lane
    );
        logic hit;
        hit = req.wr && (req.addr[7:2] == CSR_DWORD);
        return hit && req.be[lane];
    endfunction

    logic               wr_level;
    logic               wr_ctrl;
    logic [7:0]         ctrl_byte;
    logic               clear_flag;
    logic               exit_d3;

    // The low lane holds the power level, the next lane the wake bits.
    // The upper two lanes are read only and their strobes are dropped.
    assign wr_level   = lane_write(i_cfg_req, `PPM_LANE_LEVEL);
    assign wr_ctrl    = lane_write(i_cfg_req, `PPM_LANE_CTRL);
    assign ctrl_byte  = i_cfg_req.wdata[15:8];

    // Only a one written to the flag position clears it.
    assign clear_flag = wr_ctrl && ctrl_byte[`PPM_LANE_FLAG_BIT];

    // A write that takes the function from D3hot to D0.
    assign exit_d3 = wr_level
                  && (level_r == `PPM_LEVEL_D3HOT)
                  && (i_cfg_req.wdata[`PPM_LEVEL_MSB:`PPM_LEVEL_LSB]
                      == `PPM_LEVEL_D0);

    // ------------------------------------------------------------------
    // Power level field
    // ------------------------------------------------------------------

    // Any encoding is accepted, since all four states are supported.
    // The internal D3hot exit reset does not reach this register.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            level_r <= `PPM_LEVEL_D0;
        end else if (bus_rst) begin
            level_r <= `PPM_LEVEL_D0;
        end else if (wr_level) begin
            level_r <= i_cfg_req.wdata[`PPM_LEVEL_MSB:`PPM_LEVEL_LSB];
        end
    end

    // ------------------------------------------------------------------
    // Wake assert enable
    // ------------------------------------------------------------------

    // Only the global reset clears it; the bus reset and the internal
    // reset leave it alone so that a wake survives a bus reset.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wake_en_r <= 1'b0;
        end else if (wr_ctrl) begin
            wake_en_r <= ctrl_byte[`PPM_LANE_EN_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Wake event flag
    // ------------------------------------------------------------------

    // An event in the same cycle as a clear or a bus reset keeps the flag
    // set, so a wake request is never dropped on the floor.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wake_flag_r <= 1'b0;
        end else if (i_wake_event) begin
            wake_flag_r <= 1'b1;
        end else if (bus_rst && !wake_en_r) begin
            wake_flag_r <= 1'b0;
        end else if (clear_flag) begin
            wake_flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Wake pin drive
    // ------------------------------------------------------------------

    // The pin is open drain: it only ever pulls low, so the output level
    // is held at zero and the enable alone decides the wire.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wake_pin_out <= 1'b0;
        end else begin
            o_wake_pin_out <= 1'b0;
        end
    end

    // Drive low while the flag is set and the enable allows it.  The
    // next-state terms are used so that a clear releases the pin in the
    // same edge that clears the flag.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wake_pin_oe_b <= 1'b1;
        end else begin
            o_wake_pin_oe_b <= ~(wake_en_nxt() && wake_flag_nxt());
        end
    end

    // Next value of the enable, mirroring its register above.
    function automatic logic wake_en_nxt();
        return wr_ctrl ? ctrl_byte[`PPM_LANE_EN_BIT] : wake_en_r;
    endfunction

    // Next value of the flag, mirroring its register above.
    function automatic logic wake_flag_nxt();
        logic v;
        v = wake_flag_r;
        if (i_wake_event) begin
            v = 1'b1;
        end else if (bus_rst && !wake_en_r) begin
            v = 1'b0;
        end else if (clear_flag) begin
            v = 1'b0;
        end
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Internal reset on D3hot exit
    // ------------------------------------------------------------------

    // One cycle pulse to the rest of the function.  Context bits and
    // global-reset-only bits elsewhere must ignore it; this block's own
    // registers are deliberately not wired to it.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_d3_exit_reset <= 1'b0;
        end else begin
            o_d3_exit_reset <= exit_d3;
        end
    end

    // ------------------------------------------------------------------
    // Exported power level
    // ------------------------------------------------------------------

    // Registered copy for the rest of the function.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_power_level <= `PPM_LEVEL_D0;
        end else if (bus_rst) begin
            o_power_level <= `PPM_LEVEL_D0;
        end else if (wr_level) begin
            o_power_level <= i_cfg_req.wdata[`PPM_LEVEL_MSB:`PPM_LEVEL_LSB];
        end
    end

    // ------------------------------------------------------------------
    // Secondary bus control
    // ------------------------------------------------------------------

    // The sequencer follows the stored level, one cycle behind a write.
    ppm_secbus_ctl u_secbus (
        .i_clock   (i_clock),
        .i_rst_b   (i_rst_b),
        .i_level   (level_r),
        .i_secondary_bus_power_clock_ctl (SECONDARY_BUS_POWER_CLOCK_CTL),
        .i_b2b3    (B2B3_SEL),
        .o_sec     (o_sec_bus)
    );

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------

    logic [15:0]        csr_word;
    logic [31:0]        rd_word;

    // Unlisted bits of the control word stay zero: the multiplier, the
    // selector and the reserved span all read as zeros.
    always_comb begin
        csr_word = `PPM_CSR_RESET;
        csr_word[`PPM_FLAG_BIT] = wake_flag_r;
        csr_word[`PPM_EN_BIT]   = wake_en_r;
        csr_word[`PPM_LEVEL_MSB:`PPM_LEVEL_LSB] = level_r;
    end

    // Other dwords in this window answer with zero data.
    always_comb begin
        rd_word = {DATA_VALUE, BSE_VALUE, `PPM_CSR_RESET};
        if (i_cfg_req.addr[7:2] == CSR_DWORD) begin
            rd_word = {DATA_VALUE, BSE_VALUE, csr_word};
        end else begin
            rd_word = {`PPM_DATA_RESET, `PPM_DATA_RESET, `PPM_CSR_RESET};
        end
    end

    // ------------------------------------------------------------------
    // Answer
    // ------------------------------------------------------------------

    // Every request is answered one cycle after it is taken; writes
    // return zero data.  Reads have no side effects.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_cfg_rsp.ack   <= 1'b0;
            o_cfg_rsp.rdata <= {`PPM_DATA_RESET, `PPM_DATA_RESET, `PPM_CSR_RESET};
        end else begin
            o_cfg_rsp.ack   <= i_cfg_req.rd || i_cfg_req.wr;
            o_cfg_rsp.rdata <= i_cfg_req.rd ? rd_word
                             : {`PPM_DATA_RESET, `PPM_DATA_RESET, `PPM_CSR_RESET};
        end
    end

endmodule

`default_nettype wire

// ==== verilog/ppm_pkg.sv ====
`default_nettype none
`include "ppm_consts.svh"

package ppm_pkg;

    // ------------------------------------------------------------------
    // Configuration access carriers
    // ------------------------------------------------------------------
    // One configuration request, dword addressed by byte address.
    typedef struct packed {
        logic                       wr;
        logic                       rd;
        logic [`PPM_ADDR_W-1:0]     addr;
        logic [`PPM_BE_W-1:0]       be;
        logic [`PPM_DATA_W-1:0]     wdata;
    } ppm_cfg_req_s;

    // Answer to a request, valid for one cycle.
    typedef struct packed {
        logic                       ack;
        logic [`PPM_DATA_W-1:0]     rdata;
    } ppm_cfg_rsp_s;

    // Secondary bus controls.
    typedef struct packed {
        logic                       clk_stop;
        logic                       power_off;
    } ppm_sec_bus_s;

    // Secondary bus condition.
    typedef enum logic [1:0] {
        SB_ON,
        SB_CLK_STOPPED,
        SB_POWER_OFF
    } ppm_sec_state_e;

    typedef logic [1:0] ppm_level_t;

endpackage

`default_nettype wire

// ==== verilog/ppm_secbus_ctl.sv ====
`default_nettype none
`include "ppm_consts.svh"

// ----------------------------------------------------------------------
// Secondary bus clock and power sequencing.
// ----------------------------------------------------------------------
module ppm_secbus_ctl
    import ppm_pkg::*;
(
    input  wire logic           i_clock,
    input  wire logic           i_rst_b,
    input  wire ppm_level_t     i_level,
    input  wire logic           i_secondary_bus_power_clock_ctl,
    input  wire logic           i_b2b3,
    output ppm_sec_bus_s        o_sec
);

    ppm_sec_state_e     state_r;
    ppm_sec_state_e     state_nxt;

    // Pick the action for D3hot; without bus control the level is ignored.
    always_comb begin
        state_nxt = SB_ON;
        case (state_r)
            SB_ON, SB_CLK_STOPPED, SB_POWER_OFF: begin
                if (i_secondary_bus_power_clock_ctl && (i_level == `PPM_LEVEL_D3HOT)) begin
                    state_nxt = i_b2b3 ? SB_CLK_STOPPED : SB_POWER_OFF;
                end
            end
            default: begin
                state_nxt = SB_ON;
            end
        endcase
    end

    // State and registered controls move together.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r         <= SB_ON;
            o_sec.clk_stop  <= 1'b0;
            o_sec.power_off <= 1'b0;
        end else begin
            state_r         <= state_nxt;
            o_sec.clk_stop  <= (state_nxt == SB_CLK_STOPPED);
            o_sec.power_off <= (state_nxt == SB_POWER_OFF);
        end
    end

endmodule

`default_nettype wire

// ==== verilog/ppm_sync2.sv ====
`default_nettype none

// ----------------------------------------------------------------------
// Two flop synchroniser, resets to the asserted level of a low pin.
// ----------------------------------------------------------------------
module ppm_sync2 (
    input  wire logic   i_clock,
    input  wire logic   i_rst_b,
    input  wire logic   i_async,
    output logic        o_sync
);

    logic               meta_r;

    // Only the second flop reads the first one, to contain metastability.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_r <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end

endmodule

`default_nettype wire
